/* logic/acr_adc_ctrl.sv */
// converter control, clock divider, result lock and apb register slave
// Functional notes
// - channel change mid-conversion aborts it, clears done flag, restarts on new channel
// - reading low result byte locks both result bytes
// - lock released by reading high result byte or clearing converter enable
// - while locked, results keep their sample; new ones load after high read
// - done flag set on completion, cleared by high read or control write
// - slow/speed pick converter clock: /2, undivided, /4, /2
// - enable clear stops conversion; enable set starts converting
// - four-bit input select picks analogue input 0 to 15
// - high byte shows result 9:2; low byte shows 1:0, upper bits zero
// - control bits read/write except read-only done flag; result bytes read-only
// - all three registers read zero after reset
// - cpu wait mode leaves conversion running
// - halt disables converter; controller waits a settle time after wakeup
// - enabled converter converts the selected input continuously
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module acr_adc_ctrl
  import acr_pkg::*;
(
  input  wire logic                   pclk,        // apb clock, 50 MHz
  input  wire logic                   presetn,     // async reset, active low
  input  wire logic                   psel,        // apb select
  input  wire logic                   penable,     // apb access phase
  input  wire logic                   pwrite,      // apb direction
  input  wire logic [11:0]            paddr,       // apb byte address
  input  wire logic [31:0]            pwdata,      // apb write data
  output logic      [31:0]            prdata,      // apb read data
  output logic                        pready,      // apb ready
  output logic                        pslverr,     // apb error on unmapped address
  input  wire logic                   halt_mode,   // cpu in halt
  input  wire logic [9:0]             sample_data, // finished sample from core
  input  wire logic                   sample_done, // one-cycle completion strobe
  output acr_pkg::acr_core_req_s      core_req     // control toward analogue core
);
  import acr_pkg::*;

  acr_ctrl_s     ctrl_q, ctrl_d;
  acr_state_e    state_q, state_d;
  acr_core_req_s req_q, req_d;
  logic [9:0]    res_q, res_d;
  logic          lock_q, lock_d;
  logic          wake_pend_q, wake_pend_d;
  logic [15:0]   settle_q, settle_d;
  logic [1:0]    div_q, div_d;
  logic [31:0]   rdata_q, rdata_d;
  logic          err_q, err_d;

  logic access, setup, wr_ctrl, rd_hi, rd_lo, en_new, chan_change, done_ok, cap, tick;

  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = err_q;
  assign core_req = req_q;

  always_comb begin
    // bus and strobe decode
    access      = psel & penable;
    setup       = psel & ~penable;
    wr_ctrl     = access & pwrite & (paddr == ADDR_CTRL);
    rd_hi       = access & ~pwrite & (paddr == ADDR_RES_HI);
    rd_lo       = access & ~pwrite & (paddr == ADDR_RES_LO);
    en_new      = wr_ctrl ? pwdata[5] : ctrl_q.enable;
    chan_change = wr_ctrl & (pwdata[3:0] != ctrl_q.input_select) & (state_q == ST_CONV);
    // a strobe racing a channel change belongs to the old input, so drop it
    done_ok     = sample_done & (state_q == ST_CONV) & ~chan_change;

  end

  always_comb begin
    // control register; done flag never written by software
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.speed        = pwdata[6];
      ctrl_d.enable       = pwdata[5];
      ctrl_d.slow         = pwdata[4];
      ctrl_d.input_select = pwdata[3:0];
    end
    // set beats clear when completion and clear meet
    if (done_ok)
      ctrl_d.eoc = 1'b1;
    else if (wr_ctrl | rd_hi)
      ctrl_d.eoc = 1'b0;

  end

  always_comb begin
    // result lock keeps the two bytes from one sample
    if (rd_hi | ~en_new)
      lock_d = 1'b0;
    else if (rd_lo)
      lock_d = 1'b1;
    else
      lock_d = lock_q;
    // the high read that unlocks may admit the sample arriving with it
    cap   = done_ok & (~lock_q | rd_hi);
    res_d = cap ? sample_data : res_q;

  end

  always_comb begin
    // converter clock divider
    div_d = (state_q == ST_IDLE) ? DIV_RST : div_q + 2'h1;
    if (ctrl_q.speed & ~ctrl_q.slow)
      tick = 1'b1;
    else if (ctrl_q.slow & ~ctrl_q.speed)
      tick = (div_q == DIV4_LAST);
    else
      tick = div_q[0];

  end

  always_comb begin
    // one-hot sequencer; halt overrides every other request
    state_d     = state_q;
    settle_d    = settle_q;
    wake_pend_d = halt_mode ? 1'b1 : wake_pend_q;
    req_d       = '0;
    case (state_q)
      ST_IDLE: begin
        if (en_new & ~halt_mode) begin
          if (wake_pend_q) begin
            state_d  = ST_SETTLE;
            settle_d = 16'h0000;
          end else begin
            state_d     = ST_CONV;
            req_d.start = 1'b1;
          end
        end
      end
      ST_SETTLE: begin
        if (~en_new | halt_mode) begin
          state_d = ST_IDLE;
        end else if (settle_q == SETTLE_LAST) begin
          state_d     = ST_CONV;
          req_d.start = 1'b1;
          wake_pend_d = 1'b0;
        end else begin
          settle_d = settle_q + 16'h0001;
        end
      end
      ST_CONV: begin
        if (~en_new | halt_mode) begin
          state_d     = ST_IDLE;
          req_d.abort = 1'b1;
        end else if (chan_change) begin
          req_d.abort = 1'b1;
          req_d.start = 1'b1;
        end else if (done_ok) begin
          req_d.start = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // wait mode has no say here, so conversion keeps running through it
    req_d.enable       = (state_d != ST_IDLE);
    req_d.clk_tick     = tick & (state_q != ST_IDLE);
    req_d.input_select = ctrl_d.input_select;

  end

  always_comb begin
    // read data is prepared in the setup phase so the slave never waits
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      err_d = ~pwrite & (paddr != ADDR_CTRL) & (paddr != ADDR_RES_HI) & (paddr != ADDR_RES_LO);
      err_d = err_d | (pwrite & (paddr != ADDR_CTRL) & (paddr != ADDR_RES_HI)
                       & (paddr != ADDR_RES_LO));
      case (paddr)
        ADDR_CTRL:   rdata_d = {24'h000000, ctrl_q};
        ADDR_RES_HI: rdata_d = {24'h000000, res_q[9:2]};
        ADDR_RES_LO: rdata_d = {30'h00000000, res_q[1:0]};
        default:     rdata_d = 32'h00000000;
      endcase
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= acr_ctrl_s'(CTRL_RST);
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // result bytes and their lock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q  <= RES_RST;
      lock_q <= 1'b0;
    end else begin
      res_q  <= res_d;
      lock_q <= lock_d;
    end
  end

  // converter clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= DIV_RST;
    end else begin
      div_q <= div_d;
    end
  end

  // sequencer and requests toward the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= ST_IDLE;
      req_q       <= '0;
      wake_pend_q <= 1'b0;
      settle_q    <= 16'h0000;
    end else begin
      state_q     <= state_d;
      req_q       <= req_d;
      wake_pend_q <= wake_pend_d;
      settle_q    <= settle_d;
    end
  end

  // held until the next setup so the access phase sees a stable word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h00000000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  lock_hold_a: assert property (lock_q && !rd_hi |=> $stable(res_q))
    else $error("locked result changed");
  lock_set_a: assert property (rd_lo && en_new |=> lock_q)
    else $error("low byte read did not lock");
  unlock_a: assert property (rd_hi || (wr_ctrl && !pwdata[5]) |=> !lock_q)
    else $error("lock not released");
  eoc_set_a: assert property (done_ok |=> ctrl_q.eoc ##0 res_q == $past(sample_data) || $past(lock_q))
    else $error("completion not flagged");
  eoc_clear_a: assert property ((rd_hi || wr_ctrl) && !done_ok |=> !ctrl_q.eoc)
    else $error("done flag not cleared");
  chan_abort_a: assert property (chan_change && en_new && !halt_mode
                                 |=> req_q.abort && req_q.start && !ctrl_q.eoc)
    else $error("channel change did not restart");
  fast_tick_a: assert property (state_q != ST_IDLE && ctrl_q.speed && !ctrl_q.slow
                                |=> req_q.clk_tick)
    else $error("undivided clock tick missing");
  // a control write inside the window may legally change the rate, so it is excluded
  slow_tick_a: assert property (req_q.clk_tick && ctrl_q.slow && !ctrl_q.speed
                                && $stable(ctrl_q.slow) && $stable(ctrl_q.speed) && !wr_ctrl
                                ##1 !wr_ctrl |-> !req_q.clk_tick ##1 !req_q.clk_tick
                                ##1 !req_q.clk_tick)
    else $error("divide by four too fast");
  halt_off_a: assert property (halt_mode |=> !req_q.enable)
    else $error("converter on during halt");
  restart_a: assert property (done_ok && en_new && !halt_mode |=> req_q.start)
    else $error("continuous restart missing");
  low_zero_a: assert property (setup && paddr == ADDR_RES_LO |=> prdata[31:2] == 30'h0)
    else $error("low byte upper bits not zero");

  // register map and sequencer checks
  ctrl_wr_a: assert property (wr_ctrl |=> ctrl_q[6:0] == $past(pwdata[6:0]))
    else $error("control write not taken");
  sel_track_a: assert property (req_q.input_select == ctrl_q.input_select)
    else $error("input select not forwarded");
  // read data is loaded at setup, so it shows the result of the cycle before
  hi_byte_a: assert property (setup && paddr == ADDR_RES_HI
                              |=> {prdata[7:0], 2'h0} == ($past(res_q) & 10'h3FC)
                              && prdata[31:8] == 24'h000000)
    else $error("high byte wrong");
  enable_track_a: assert property (req_q.enable == (state_q != ST_IDLE))
    else $error("enable does not follow state");
  en_off_a: assert property (state_q == ST_CONV && !en_new |=> req_q.abort && !req_q.enable)
    else $error("clearing enable did not stop");
  en_on_a: assert property (state_q == ST_IDLE && en_new && !halt_mode && !wake_pend_q
                            |=> req_q.start && req_q.enable)
    else $error("setting enable did not start");
  settle_hold_a: assert property (state_q == ST_SETTLE |-> !req_q.start)
    else $error("start during settle wait");
  idle_drop_a: assert property (sample_done && state_q != ST_CONV |=> $stable(res_q))
    else $error("strobe taken while not converting");
  lock_drop_a: assert property (!en_new |=> !lock_q)
    else $error("lock held with converter off");
  state_onehot_a: assert property ($onehot(state_q))
    else $error("sequencer state not one-hot");
  res_ro_a: assert property (access && pwrite && paddr != ADDR_CTRL && !sample_done
                             |=> $stable(res_q))
    else $error("result changed by a write");
  map_err_a: assert property (setup && (paddr == ADDR_CTRL || paddr == ADDR_RES_HI
                              || paddr == ADDR_RES_LO) |=> !pslverr)
    else $error("error on mapped address");
endmodule
`default_nettype wire

/* logic/acr_pkg.sv */
// shared constants and types for the converter control and result registers
package acr_pkg;
  localparam int          CLK_PERIOD_NS   = 20;
  // settle time after halt wakeup; plain default
  localparam int          WAKE_SETTLE_NS  = 1000;
  localparam int          WAKE_SETTLE_CYC = (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] SETTLE_LAST     = 16'(WAKE_SETTLE_CYC - 1);

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTRL        = 8'h45;
  localparam logic [7:0]  IDX_RES_HI      = 8'h46;
  localparam logic [7:0]  IDX_RES_LO      = 8'h47;
  localparam logic [11:0] ADDR_CTRL       = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_RES_HI     = {2'h0, IDX_RES_HI, 2'h0};
  localparam logic [11:0] ADDR_RES_LO     = {2'h0, IDX_RES_LO, 2'h0};

  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [9:0]  RES_RST         = 10'h000;
  localparam logic [1:0]  DIV_RST         = 2'h0;
  localparam logic [1:0]  DIV4_LAST       = 2'h3;

  // control register layout, msb first
  typedef struct packed {
    logic       eoc;
    logic       speed;
    logic       enable;
    logic       slow;
    logic [3:0] input_select;
  } acr_ctrl_s;

  // request bundle toward the analogue core
  typedef struct packed {
    logic       enable;
    logic       clk_tick;
    logic       start;
    logic       abort;
    logic [3:0] input_select;
  } acr_core_req_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CONV   = 3'b100
  } acr_state_e;
endpackage

/* tb/acr_adc_ctrl_test.sv */
// self-checking bench for the converter control and result registers
`timescale 1ns/100ps
`default_nettype none
module acr_adc_ctrl_test;
  import acr_pkg::*;
  logic          pclk        = 1'b0;
  logic          presetn     = 1'b0;
  logic          psel        = 1'b0;
  logic          penable     = 1'b0;
  logic          pwrite      = 1'b0;
  logic          halt_mode   = 1'b0;
  logic          sample_done = 1'b0;
  logic [11:0]   paddr       = 12'h000;
  logic [31:0]   pwdata      = 32'h0000_0000;
  logic [9:0]    sample_data = 10'h000;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  acr_core_req_s core_req;
  int            fail_count  = 0;
  int            compares    = 0;
  int            n_start     = 0;
  int            n_abort     = 0;
  int            n_tick      = 0;
  // xorshift state starts at 91582
  logic [31:0]   rnd         = 32'h0001_65BE;
  logic [31:0]   rd;
  logic          err;
  int            t;
  always #10 pclk = ~pclk;
  acr_adc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_mode(halt_mode), .sample_data(sample_data),
    .sample_done(sample_done), .core_req(core_req));
  // pulses are tallied so checks can look at counts rather than racing single edges
  always @(posedge pclk) begin
    if (core_req.start === 1'b1) n_start <= n_start + 1;
    if (core_req.abort === 1'b1) n_abort <= n_abort + 1;
    if (core_req.clk_tick === 1'b1) n_tick <= n_tick + 1;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // ticks expected in 16 cycles for {slow, speed}
  function automatic int ticks16(input logic [1:0] sel);
    return (sel == 2'h1) ? 16 : (sel == 2'h2) ? 4 : 8;
  endfunction
  task automatic close_out;
    $display("Counts: %0d mismatches in %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, exp});
  endtask
  task automatic pulse(input logic [9:0] s);
    sample_data <= s;
    sample_done <= 1'b1;
    @(posedge pclk);
    sample_done <= 1'b0;
    sample_data <= ~s;
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    close_out();
  end
  initial begin
    logic [9:0] s1;
    logic [9:0] s2;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_RES_HI, 8'h00);
    rd_chk(ADDR_RES_LO, 8'h00);
    apb(1'b0, 12'h000, 8'h00);
    chk({31'h0, err}, 32'h1);
    rnd = xs(rnd);
    t = n_start;
    // done flag written as one, it must read back clear
    apb(1'b1, ADDR_CTRL, {4'hA, rnd[3:0]});
    rd_chk(ADDR_CTRL, {4'h2, rnd[3:0]});
    chk(32'(n_start - t), 32'h1);
    chk({31'h0, core_req.enable}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      t = n_abort;
      apb(1'b1, ADDR_CTRL, {4'h2, 4'(i)});
      repeat (2) @(posedge pclk);
      chk({28'h0, core_req.input_select}, 32'(i));
      chk(32'(n_abort - t), 32'(4'(i) != rnd[3:0] || i > 0));
    end
    rnd = xs(rnd);
    s1 = rnd[9:0];
    t = n_start;
    pulse(s1);
    chk(32'(n_start - t), 32'h1);
    rd_chk(ADDR_CTRL, 8'hAF);
    rd_chk(ADDR_RES_LO, {6'h00, s1[1:0]});
    pulse(~s1);
    rd_chk(ADDR_RES_HI, s1[9:2]);
    rd_chk(ADDR_CTRL, 8'h2F);
    apb(1'b1, ADDR_RES_HI, ~s1[9:2]);
    rnd = xs(rnd);
    s2 = rnd[9:0];
    pulse(s2);
    rd_chk(ADDR_CTRL, 8'hAF);
    rd_chk(ADDR_RES_HI, s2[9:2]);
    rd_chk(ADDR_RES_LO, {6'h00, s2[1:0]});
    apb(1'b1, ADDR_CTRL, 8'h0F);
    chk({31'h0, core_req.enable}, 32'h0);
    apb(1'b1, ADDR_CTRL, 8'h2F);
    pulse(~s2);
    rd_chk(ADDR_RES_HI, ~s2[9:2]);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_CTRL, {1'b0, k[0], 1'b1, k[1], 4'hF});
      repeat (4) @(posedge pclk);
      t = n_tick;
      repeat (16) @(posedge pclk);
      // the undivided setting is only legal on a slow cpu clock; here its tick pattern is checked
      chk(32'(n_tick - t), 32'(ticks16(k[1:0])));
    end
    // halt keeps the control bits, so conversion resumes after the settle wait
    halt_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, core_req.enable}, 32'h0);
    t = n_start;
    halt_mode <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(32'(n_start - t), 32'h0);
    repeat (25) @(posedge pclk);
    chk(32'(n_start - t), 32'h1);
    close_out();
  end
endmodule
`default_nettype wire
